// >>> src/cfsi_top.sv
// Purpose: can fifo pointer status, error state and sticky event flags
// Assumes: event inputs are one-cycle pulses on MCLK; wake-up is a pin level
// Notes: flags clear by writing zero; set wins over a same-cycle clear
import cfsi_pkg::*;

// Functional notes
// R1: read-only current fifo buffer pointer, bits 13:8
// R2: read-only next read pointer, bits 5:0
// R3: bit 13 shows transmitter bus-off
// R4: bit 12 shows transmitter error-passive
// R5: bit 11 shows receiver error-passive
// R6: bit 10 shows transmitter error-warning
// R7: bit 9 shows receiver error-warning
// R8: bit 8 ors both warning states
// R9: flags sticky; write zero clears, one ignored
// R10: bit 7 set on invalid message
// R11: bit 6 set on bus wake-up
// R12: bit 5 set when an error-state bit rises
// R13: bit 3 set on fifo almost full
// R14: bit 2 set on receive overflow
// R15: unused bits read as zero
// R16: bit 1 rx received, bit 0 tx done
// R17: states from counters at 96/128/256
module cfsi_top (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic [3:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [15:0] RDATA,
	input wire cfsi_pkg::cfsi_ptr_type PTRS,
	input wire logic [8:0] TX_ERR_CNT,
	input wire logic [8:0] RX_ERR_CNT,
	input wire logic INVALID_MSG,
	input wire logic BUS_WAKE_PIN,
	input wire logic RX_ALMOST_FULL,
	input wire logic RX_OVERFLOW,
	input wire logic RX_DONE,
	input wire logic TX_DONE,
	output logic [5:0] ERR_STATE,
	output logic [7:0] FLAGS
);
	import cfsi_pkg::*;

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [15:0] rdata;
		logic [7:0] flags;
		logic [5:0] err_prev;
		logic wake_prev;
		logic almost_prev;
		cfsi_ptr_type ptrs;
	} cfsi_st_type;

	cfsi_st_type s_q, s_d;
	logic [5:0] err_state;
	logic wake_lvl;

	cfsi_err_state u_err (
		.clk(MCLK),
		.rst_n(RST_N),
		.tx_cnt(TX_ERR_CNT),
		.rx_cnt(RX_ERR_CNT),
		.state(err_state)
	);

	// wake-up arrives from the bus pin, so it is synchronised first
	cfsi_sync #(.W(1)) u_wake (
		.clk(MCLK),
		.rst_n(RST_N),
		.din(BUS_WAKE_PIN),
		.dout(wake_lvl)
	);

	function automatic logic [5:0] clip_ptr(input logic [5:0] p);
		// codes above buffer 31 are not defined; clamp them
		clip_ptr = (p > PTR_MAX) ? PTR_MAX : p;
	endfunction : clip_ptr

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		logic [7:0] set_v;
		logic [7:0] clr_v;
		set_v = '0;
		clr_v = '0;
		s_d = s_q;
		s_d.ptrs.cur_ptr = clip_ptr(PTRS.cur_ptr); // R1
		s_d.ptrs.next_ptr = clip_ptr(PTRS.next_ptr); // R2
		s_d.err_prev = err_state;
		s_d.wake_prev = wake_lvl;
		s_d.almost_prev = RX_ALMOST_FULL;
		set_v[BIT_INVALID] = INVALID_MSG; // R10
		set_v[BIT_WAKEUP] = wake_lvl & ~s_q.wake_prev; // R11
		set_v[BIT_ERROR] = |(err_state & ~s_q.err_prev); // R12
		set_v[BIT_ALMOST_FULL] = RX_ALMOST_FULL & ~s_q.almost_prev; // R13
		set_v[BIT_RX_OVERFLOW] = RX_OVERFLOW; // R14
		set_v[BIT_RX_BUFFER] = RX_DONE; // R16
		set_v[BIT_TX_BUFFER] = TX_DONE; // R16
		if (WR && ADDR == ADDR_INT_FLAGS) begin
			clr_v = ~WDATA[7:0]; // R9
		end
		// a new event beats a clear in the same cycle
		s_d.flags = ((s_q.flags & ~clr_v) | set_v) & FLAG_MASK; // R9 R15
		s_d.rdata = RESET_VALUE;
		if (RD) begin
			case (ADDR)
				ADDR_FIFO_PTR: begin
					s_d.rdata = {2'h0, s_q.ptrs.cur_ptr, 2'h0, s_q.ptrs.next_ptr}; // R1 R2 R15
				end
				ADDR_INT_FLAGS: begin
					s_d.rdata = {2'h0, err_state, s_q.flags}; // R3 R4 R5 R6 R7 R8
				end
				ADDR_ERR_CNT: begin
					s_d.rdata = {7'h00, TX_ERR_CNT};
				end
				default: begin
					s_d.rdata = RESET_VALUE;
				end
			endcase
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign RDATA = s_q.rdata;
	assign FLAGS = s_q.flags;
	assign ERR_STATE = s_q.err_prev;
endmodule : cfsi_top

// >>> src/cfsi_pkg.sv
// Purpose: shared constants and types for the can fifo status and flag block
// Assumes: one clock, synchronous active-low reset
// Notes: register offsets are word indices on the plain register port
package cfsi_pkg;
	// ****************************************
	// register map
	// ****************************************
	localparam logic [3:0] ADDR_FIFO_PTR = 4'h0;
	localparam logic [3:0] ADDR_INT_FLAGS = 4'h1;
	localparam logic [3:0] ADDR_ERR_CNT = 4'h2;
	localparam logic [15:0] RESET_VALUE = 16'h0000;
	// ****************************************
	// field positions
	// ****************************************
	localparam int CUR_PTR_LSB = 8;
	localparam int NEXT_PTR_LSB = 0;
	localparam int BIT_TX_BUS_OFF = 13;
	localparam int BIT_TX_PASSIVE = 12;
	localparam int BIT_RX_PASSIVE = 11;
	localparam int BIT_TX_WARNING = 10;
	localparam int BIT_RX_WARNING = 9;
	localparam int BIT_ANY_WARNING = 8;
	localparam int BIT_INVALID = 7;
	localparam int BIT_WAKEUP = 6;
	localparam int BIT_ERROR = 5;
	localparam int BIT_ALMOST_FULL = 3;
	localparam int BIT_RX_OVERFLOW = 2;
	localparam int BIT_RX_BUFFER = 1;
	localparam int BIT_TX_BUFFER = 0;
	localparam logic [7:0] FLAG_MASK = 8'hef;
	// ****************************************
	// error thresholds and pointer limit
	// ****************************************
	localparam logic [8:0] WARN_LIMIT = 9'h060;
	localparam logic [8:0] PASSIVE_LIMIT = 9'h080;
	localparam logic [8:0] BUS_OFF_LIMIT = 9'h100;
	localparam logic [5:0] PTR_MAX = 6'h1f;

	typedef struct packed {
		logic invalid_msg;
		logic wakeup;
		logic rx_almost_full;
		logic rx_overflow;
		logic rx_done;
		logic tx_done;
	} cfsi_event_type;

	typedef struct packed {
		logic [5:0] cur_ptr;
		logic [5:0] next_ptr;
	} cfsi_ptr_type;

	typedef struct packed {
		logic [3:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} cfsi_bus_type;
endpackage : cfsi_pkg

// >>> src/cfsi_err_state.sv
// Purpose: error-confinement state from tx and rx error counters
// Assumes: counters are same-clock values, saturated by the caller
// Notes: six state bits, registered
module cfsi_err_state (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [8:0] tx_cnt,
	input wire logic [8:0] rx_cnt,
	output logic [5:0] state
);
	import cfsi_pkg::*;
	typedef struct packed {
		logic [5:0] st;
	} cfsi_es_type;
	cfsi_es_type s_q, s_d;
	always_comb begin
		s_d = s_q;
		s_d.st[5] = (tx_cnt >= BUS_OFF_LIMIT); // R17
		s_d.st[4] = (tx_cnt >= PASSIVE_LIMIT) && (tx_cnt < BUS_OFF_LIMIT); // R17
		s_d.st[3] = (rx_cnt >= PASSIVE_LIMIT); // R17
		s_d.st[2] = (tx_cnt >= WARN_LIMIT); // R17
		s_d.st[1] = (rx_cnt >= WARN_LIMIT); // R17
		s_d.st[0] = s_d.st[2] | s_d.st[1]; // R8
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign state = s_q.st;
endmodule : cfsi_err_state

// >>> src/cfsi_sync.sv
// Purpose: two-stage synchroniser for pin-level inputs
// Assumes: inputs are levels from outside the clock domain
// Notes: first stage is read only by the second
module cfsi_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} cfsi_sy_type;
	cfsi_sy_type s_q, s_d;
	always_comb begin
		s_d.s1 = din;
		s_d.s2 = s_q.s1;
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign dout = s_q.s2;
endmodule : cfsi_sync

// >>> test/cfsi_can_node.sv
// Purpose: far-side bus node
// Assumes: requests from bench
// Notes: wake level held; no bus timing
module cfsi_can_node (
	input wire logic clk,
	input wire logic wake_req,
	input wire logic bad_req,
	output logic wake_pin = 1'b0,
	output logic invalid_msg = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	// pin lands off the edge, as a real wire would
	always @(posedge clk) begin
		wake_pin <= #1 wake_req;
		invalid_msg <= bad_req;
	end
endmodule : cfsi_can_node

// >>> test/cfsi_props.sv
// Purpose: port checks for cfsi_top
// Assumes: bound to cfsi_top
// Notes: state may lag counters two cycles
module cfsi_props (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic [3:0] ADDR,
	input wire logic WR,
	input wire logic RD,
	input wire logic [15:0] RDATA,
	input wire logic [8:0] TX_ERR_CNT,
	input wire logic INVALID_MSG,
	input wire logic RX_OVERFLOW,
	input wire logic TX_DONE,
	input wire logic [5:0] ERR_STATE,
	input wire logic [7:0] FLAGS
);
	timeunit 1ns;
	timeprecision 1ps;
	import cfsi_pkg::*;
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	sequence no_clr;
		!WR || ADDR != ADDR_INT_FLAGS;
	endsequence
	sequence tx_off;
		(TX_ERR_CNT >= BUS_OFF_LIMIT) [*3];
	endsequence
	inv_set_a: assert property (INVALID_MSG |=> FLAGS[7])
		else $error("invalid flag not set");
	ovf_set_a: assert property (RX_OVERFLOW |=> FLAGS[2])
		else $error("overflow flag not set");
	tx_done_a: assert property (TX_DONE |=> FLAGS[0])
		else $error("tx flag not set");
	hole_zero_a: assert property (FLAGS[4] == 1'b0)
		else $error("unused flag set");
	flags_sticky_a: assert property (no_clr |=> (FLAGS & $past(FLAGS)) == $past(FLAGS))
		else $error("flag dropped");
	bus_off_a: assert property (tx_off |-> ERR_STATE[5])
		else $error("bus off missing");
	warn_any_a: assert property (ERR_STATE[0] == (ERR_STATE[1] | ERR_STATE[2]))
		else $error("warning or wrong");
	err_flag_a: assert property (|(ERR_STATE & ~$past(ERR_STATE)) |-> ##[0:2] FLAGS[5])
		else $error("error flag not set");
	ptr_pad_a: assert property (RD && ADDR == ADDR_FIFO_PTR |=> RDATA[15:14] == 2'h0 && RDATA[7:6] == 2'h0)
		else $error("pointer pad not zero");
endmodule : cfsi_props
bind cfsi_top cfsi_props u_props (.MCLK, .RST_N, .ADDR, .WR, .RD, .RDATA, .TX_ERR_CNT,
	.INVALID_MSG, .RX_OVERFLOW, .TX_DONE, .ERR_STATE, .FLAGS);

// >>> test/test_cfsi_top.sv
// Purpose: self-checking bench for cfsi_top
// Assumes: 4 ns clock, sync reset
// Notes: flags left set between steps on purpose; t_flags clears them all at its end
module test_cfsi_top;
	timeunit 1ns;
	timeprecision 1ps;
	import cfsi_pkg::*;
	logic MCLK = 0, RST_N = 0, WR = 0, RD = 0, wake = 0, bad = 0;
	logic [3:0] ADDR = 4'h0, ev = 4'h0;
	logic [15:0] WDATA = 16'h0000, RDATA;
	logic [8:0] tx = 9'h000, rx = 9'h000;
	cfsi_ptr_type PTRS = 12'h000;
	logic BUS_WAKE_PIN, INVALID_MSG;
	logic [5:0] ERR_STATE;
	logic [7:0] FLAGS;
	int error_cnt = 0, checked = 0;
	always #2 MCLK = ~MCLK;
	cfsi_can_node node (.clk(MCLK), .wake_req(wake), .bad_req(bad),
		.wake_pin(BUS_WAKE_PIN), .invalid_msg(INVALID_MSG));
	cfsi_top DUT (.MCLK, .RST_N, .ADDR, .WDATA, .WR, .RD, .RDATA, .PTRS,
		.TX_ERR_CNT(tx), .RX_ERR_CNT(rx), .INVALID_MSG, .BUS_WAKE_PIN,
		.RX_ALMOST_FULL(ev[3]), .RX_OVERFLOW(ev[2]), .RX_DONE(ev[1]),
		.TX_DONE(ev[0]), .ERR_STATE, .FLAGS);
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge MCLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge MCLK);
		WR <= 1'b0;
	endtask : wr
	task rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge MCLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge MCLK);
		RD <= 1'b0;
		#1 chk("rdata", e, RDATA);
	endtask : rd
	task t_ptr;
		PTRS <= 12'h7c0;
		rd(ADDR_FIFO_PTR, 16'h1f00);
		PTRS <= 12'h05e;
		rd(ADDR_FIFO_PTR, 16'h011e);
		rd(4'hf, 16'h0000);
	endtask : t_ptr
	task t_flags;
		for (int i = 0; i < 4; i++) begin
			@(posedge MCLK);
			ev <= 4'h1 << i;
			@(posedge MCLK);
			ev <= 4'h0;
			repeat (2) @(posedge MCLK);
			#1 chk("flags", (16'h0002 << i) - 16'h0001, {8'h00, FLAGS});
		end
		@(posedge MCLK);
		bad <= 1'b1;
		@(posedge MCLK);
		bad <= 1'b0;
		wake <= 1'b1;
		// synchroniser plus edge detect needs several cycles
		repeat (8) @(posedge MCLK);
		#1 chk("flags", 16'h00cf, {8'h00, FLAGS});
		wr(ADDR_INT_FLAGS, 16'hffff);
		rd(ADDR_INT_FLAGS, 16'h00cf);
		wr(ADDR_INT_FLAGS, 16'hff7f);
		rd(ADDR_INT_FLAGS, 16'h004f);
		wr(ADDR_INT_FLAGS, 16'h0000);
		rd(ADDR_INT_FLAGS, 16'h0000);
	endtask : t_flags
	task t_err;
		logic [8:0] tv [5] = '{9'h05f, 9'h060, 9'h080, 9'h100, 9'h000};
		logic [5:0] es [5] = '{6'h00, 6'h05, 6'h15, 6'h25, 6'h0b};
		for (int i = 0; i < 5; i++) begin
			tx <= tv[i];
			rx <= (i == 4) ? 9'h080 : 9'h000;
			repeat (4) @(posedge MCLK);
			rd(ADDR_INT_FLAGS, {2'h0, es[i], (i > 0) ? 8'h20 : 8'h00});
			chk("err_state", {10'h000, es[i]}, {10'h000, ERR_STATE});
			rd(ADDR_ERR_CNT, {7'h00, tv[i]});
		end
	endtask : t_err
	task results;
		if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : results
	initial begin
		repeat (4) @(posedge MCLK);
		RST_N <= 1'b1;
		rd(ADDR_INT_FLAGS, 16'h0000);
		t_ptr;
		t_flags;
		t_err;
		results;
	end
	// far above the roughly 90 cycles the tests use
	initial begin
		repeat (3000) @(posedge MCLK);
		error_cnt++;
		results;
	end
endmodule : test_cfsi_top
